//--- hdl/fdcu_top.sv
// float divide and greater-than compare unit
`timescale 1ns/10ps
module fdcu_top (
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic clk_en_i,
   // request
   input wire logic start_i,
   input wire logic op_cmp_i,
   input wire logic exec_i,
   input wire logic [15:0] a_lo_i,
   input wire logic [15:0] a_hi_i,
   input wire logic [15:0] b_lo_i,
   input wire logic [15:0] b_hi_i,
   input wire logic err_clr_i,
   // answer
   output logic busy_o,
   output logic done_o,
   output logic [15:0] quo_lo_o,
   output logic [15:0] quo_hi_o,
   output logic ovf_o,
   output logic div_err_o,
   output logic gt_o
);
   typedef enum logic [0:0] {ST_IDLE, ST_DIV} fdcu_state_t;

   // ****************************************************
   // helpers
   // ****************************************************
   // denormals count as zero; operands are kept finite by the caller
   function automatic logic fdcu_is_zero(input logic [31:0] f);
      return f[fdcu_pkg::EXP_HI:fdcu_pkg::EXP_LO] == fdcu_pkg::EXP_ZERO;
   endfunction

   function automatic logic fdcu_gt(input logic [31:0] a,
                                    input logic [31:0] b);
      logic az;
      logic bz;
      az = fdcu_is_zero(a);
      bz = fdcu_is_zero(b);
      if (az && bz)
         return 1'b0;
      else if (az)
         return b[fdcu_pkg::SIGN_POS];
      else if (bz)
         return !a[fdcu_pkg::SIGN_POS];
      else if (a[fdcu_pkg::SIGN_POS] != b[fdcu_pkg::SIGN_POS])
         return !a[fdcu_pkg::SIGN_POS];
      else if (!a[fdcu_pkg::SIGN_POS])
         return a[30:0] > b[30:0];
      else
         return a[30:0] < b[30:0];
   endfunction

   function automatic logic [31:0] fdcu_limit(input logic s);
      return {s, fdcu_pkg::FLT_MAX_MAG};
   endfunction

   // ****************************************************
   // state
   // ****************************************************
   fdcu_state_t st_q, st_d;
   logic [31:0] res_q, res_d;
   logic ovf_q, ovf_d;
   logic err_q, err_d;
   logic gt_q, gt_d;
   logic done_q, done_d;
   logic sgn_q, sgn_d;
   logic signed [9:0] exp_q, exp_d;
   logic signed [9:0] exp_n;
   logic div_go;
   logic div_done;
   logic [25:0] div_quo;
   logic [31:0] a_w, b_w;

   assign a_w = {a_hi_i, a_lo_i};
   assign b_w = {b_hi_i, b_lo_i};

   fdcu_mant_div #(
      .MW(fdcu_pkg::MANT_W),
      .QW(fdcu_pkg::QUO_W)
   ) u_div (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .clk_en_i(clk_en_i),
      .start_i(div_go),
      .dividend_i({1'b1, a_w[22:0]}),
      .divisor_i({1'b1, b_w[22:0]}),
      .done_o(div_done),
      .quot_o(div_quo)
   );

   // ****************************************************
   // next state
   // ****************************************************
   always_comb begin
      st_d = st_q;
      res_d = res_q;
      ovf_d = ovf_q;
      gt_d = gt_q;
      sgn_d = sgn_q;
      exp_d = exp_q;
      done_d = 1'b0;
      div_go = 1'b0;
      exp_n = exp_q - (div_quo[25] ? 10'sd0 : 10'sd1);
      // a new error in the same cycle beats the clear
      err_d = err_clr_i ? 1'b0 : err_q;
      unique case (st_q)
         ST_IDLE: begin
            if (start_i) begin
               if (op_cmp_i) begin
                  // sources are only read, never written
                  gt_d = exec_i && fdcu_gt(a_w, b_w);
                  done_d = 1'b1;
               end else if (!exec_i) begin
                  ovf_d = 1'b0;
                  done_d = 1'b1;
               end else if (fdcu_is_zero(b_w)) begin
                  res_d = fdcu_limit(a_w[31] ^ b_w[31]);
                  ovf_d = 1'b1;
                  err_d = 1'b1;
                  done_d = 1'b1;
               end else if (fdcu_is_zero(a_w)) begin
                  res_d = {a_w[31] ^ b_w[31], fdcu_pkg::FLT_ZERO_MAG};
                  ovf_d = 1'b0;
                  done_d = 1'b1;
               end else begin
                  div_go = 1'b1;
                  sgn_d = a_w[31] ^ b_w[31];
                  exp_d = $signed({2'b00, a_w[30:23]})
                        - $signed({2'b00, b_w[30:23]})
                        + fdcu_pkg::EXP_BIAS;
                  st_d = ST_DIV;
               end
            end
         end
         ST_DIV: begin
            if (div_done) begin
               st_d = ST_IDLE;
               done_d = 1'b1;
               if (exp_n > fdcu_pkg::EXP_MAX) begin
                  res_d = fdcu_limit(sgn_q);
                  ovf_d = 1'b1;
               end else if (exp_n < fdcu_pkg::EXP_MIN) begin
                  // underflow flushes to signed zero
                  res_d = {sgn_q, fdcu_pkg::FLT_ZERO_MAG};
                  ovf_d = 1'b0;
               end else begin
                  // truncating: cheaper than rounding, off by one ulp at most
                  res_d = {sgn_q, exp_n[7:0],
                     div_quo[25] ? div_quo[24:2] : div_quo[23:1]};
                  ovf_d = 1'b0;
               end
            end
         end
      endcase
   end

   // ****************************************************
   // registers
   // ****************************************************
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_q <= ST_IDLE;
         res_q <= fdcu_pkg::RES_RST;
         ovf_q <= 1'b0;
         err_q <= 1'b0;
         gt_q <= 1'b0;
         done_q <= 1'b0;
         sgn_q <= 1'b0;
         exp_q <= '0;
      end else if (clk_en_i) begin
         st_q <= st_d;
         res_q <= res_d;
         ovf_q <= ovf_d;
         err_q <= err_d;
         gt_q <= gt_d;
         done_q <= done_d;
         sgn_q <= sgn_d;
         exp_q <= exp_d;
      end
   end

   assign busy_o = st_q != ST_IDLE;
   assign done_o = done_q;
   assign quo_lo_o = res_q[15:0];
   assign quo_hi_o = res_q[31:16];
   assign ovf_o = ovf_q;
   assign div_err_o = err_q;
   assign gt_o = gt_q;

   // ****************************************************
   // checks
   // ****************************************************
   // ordering key on a two's complement line, kept apart from fdcu_gt
   function automatic logic signed [32:0] fdcu_key(input logic [31:0] f);
      logic signed [32:0] m;
      m = {2'b00, f[fdcu_pkg::EXP_HI:0]};
      if (f[fdcu_pkg::EXP_HI:fdcu_pkg::EXP_LO] == fdcu_pkg::EXP_ZERO)
         m = '0;
      return f[fdcu_pkg::SIGN_POS] ? -m : m;
   endfunction

   AST_DIV_FINISHES: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i || !clk_en_i)
      (start_i && !busy_o && !op_cmp_i && exec_i
         && !fdcu_is_zero(a_w) && !fdcu_is_zero(b_w))
      |=> busy_o ##[26:30] done_o && !busy_o)
      else $error("divide did not finish in time");

   AST_OVF_LIMIT: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i || !clk_en_i)
      $rose(done_o) && ovf_o && !$past(op_cmp_i, 2)
      |-> {quo_hi_o[14:0], quo_lo_o} == fdcu_pkg::FLT_MAX_MAG)
      else $error("overflow without limit value");

   AST_ZERO_DIVISOR: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i || !clk_en_i)
      (start_i && !busy_o && !op_cmp_i && exec_i && fdcu_is_zero(b_w))
      |=> done_o && ovf_o && div_err_o
         && {quo_hi_o[14:0], quo_lo_o} == fdcu_pkg::FLT_MAX_MAG)
      else $error("zero divisor not handled");

   AST_NO_EXEC_DIV: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i || !clk_en_i)
      (start_i && !busy_o && !op_cmp_i && !exec_i)
      |=> done_o && !ovf_o && $stable({quo_hi_o, quo_lo_o}))
      else $error("idle divide changed state");

   AST_GT_VALUE: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i || !clk_en_i)
      (start_i && !busy_o && op_cmp_i && exec_i)
      |=> done_o
         && gt_o == (fdcu_key($past(a_w)) > fdcu_key($past(b_w))))
      else $error("compare result wrong");

   AST_CMP_NO_WRITE: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i || !clk_en_i)
      (start_i && !busy_o && op_cmp_i)
      |=> $stable({quo_hi_o, quo_lo_o}) && $stable(ovf_o))
      else $error("compare wrote divide outputs");

   AST_CMP_OFF: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i || !clk_en_i)
      (start_i && !busy_o && op_cmp_i && !exec_i) |=> !gt_o)
      else $error("compare output not forced off");

   AST_HALVES_ONE: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i || !clk_en_i)
      (start_i && !busy_o && !op_cmp_i && exec_i && a_w == b_w
         && !fdcu_is_zero(a_w))
      |-> ##[27:31] done_o && quo_hi_o == 16'h3f80 && quo_lo_o == 16'h0000)
      else $error("x divided by x is not one");
endmodule

//--- hdl/fdcu_pkg.sv
// constants shared by the float divide / compare unit
package fdcu_pkg;
   // ****************************************************
   // operand layout
   // ****************************************************
   localparam int HALF_W = 16;
   localparam int FLT_W = 32;
   localparam int SIGN_POS = 31;
   localparam int EXP_HI = 30;
   localparam int EXP_LO = 23;
   localparam int MANT_W = 24;
   localparam int QUO_W = 26;
   // ****************************************************
   // values
   // ****************************************************
   // largest finite single, about 3.40282e38
   localparam logic [30:0] FLT_MAX_MAG = 31'h7f7fffff;
   localparam logic [30:0] FLT_ZERO_MAG = 31'h00000000;
   localparam logic [31:0] RES_RST = 32'h00000000;
   localparam logic signed [9:0] EXP_BIAS = 10'sh07f;
   localparam logic signed [9:0] EXP_MAX = 10'sh0fe;
   localparam logic signed [9:0] EXP_MIN = 10'sh001;
   localparam logic [7:0] EXP_ZERO = 8'h00;
endpackage

//--- hdl/fdcu_mant_div.sv
// restoring mantissa divider, one quotient bit per cycle
`timescale 1ns/10ps
module fdcu_mant_div #(
   parameter int MW = 24,
   parameter int QW = 26
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic clk_en_i,
   // request
   input wire logic start_i,
   input wire logic [MW-1:0] dividend_i,
   input wire logic [MW-1:0] divisor_i,
   // answer
   output logic done_o,
   output logic [QW-1:0] quot_o
);
   localparam int CW = $clog2(QW + 1);

   logic [MW:0] rem_q, rem_d;
   logic [MW-1:0] dvs_q, dvs_d;
   logic [QW-1:0] quo_q, quo_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic run_q, run_d;
   logic done_q, done_d;
   logic ge;
   logic [MW:0] diff;

   // ****************************************************
   // next state
   // ****************************************************
   always_comb begin
      rem_d = rem_q;
      dvs_d = dvs_q;
      quo_d = quo_q;
      cnt_d = cnt_q;
      run_d = run_q;
      done_d = 1'b0;
      ge = rem_q >= {1'b0, dvs_q};
      diff = ge ? rem_q - {1'b0, dvs_q} : rem_q;
      if (start_i) begin
         rem_d = {1'b0, dividend_i};
         dvs_d = divisor_i;
         quo_d = '0;
         cnt_d = CW'(QW);
         run_d = 1'b1;
      end else if (run_q) begin
         // remainder stays below twice the divisor, so one spare bit is enough
         quo_d = {quo_q[QW-2:0], ge};
         rem_d = {diff[MW-1:0], 1'b0};
         cnt_d = cnt_q - CW'(1);
         if (cnt_q == CW'(1)) begin
            run_d = 1'b0;
            done_d = 1'b1;
         end
      end
   end

   // ****************************************************
   // registers
   // ****************************************************
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rem_q <= '0;
         dvs_q <= '0;
         quo_q <= '0;
         cnt_q <= '0;
         run_q <= 1'b0;
         done_q <= 1'b0;
      end else if (clk_en_i) begin
         rem_q <= rem_d;
         dvs_q <= dvs_d;
         quo_q <= quo_d;
         cnt_q <= cnt_d;
         run_q <= run_d;
         done_q <= done_d;
      end
   end

   assign done_o = done_q;
   assign quot_o = quo_q;
endmodule

//--- tb/fdcu_top_tb_top.sv
// self-checking bench for the float divide / compare unit
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module fdcu_top_tb_top;
   // ****************************************************
   // signals
   // ****************************************************
   logic mclk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic clk_en_i = 1'b1;
   logic start_i = 1'b0;
   logic op_cmp_i = 1'b0;
   logic exec_i = 1'b0;
   logic [15:0] a_lo_i = 16'h0000;
   logic [15:0] a_hi_i = 16'h0000;
   logic [15:0] b_lo_i = 16'h0000;
   logic [15:0] b_hi_i = 16'h0000;
   logic err_clr_i = 1'b0;
   logic busy_o;
   logic done_o;
   logic [15:0] quo_lo_o;
   logic [15:0] quo_hi_o;
   logic ovf_o;
   logic div_err_o;
   logic gt_o;
   int error_cnt = 0;
   int cmp_count = 0;
   // compare table: a, b, execution, expected evaluation
   logic [31:0] ca [9] = '{32'h4455c000, 32'h44555000, 32'h44555000,
      32'hc0000000, 32'hc0800000, 32'h00000000, 32'h80000000,
      32'h3f800000, 32'h4455c000};
   logic [31:0] cb [9] = '{32'h44555000, 32'h4455c000, 32'h44555000,
      32'hc0800000, 32'hc0000000, 32'h80000000, 32'h00000000,
      32'hbf800000, 32'h44555000};
   logic cx [9] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
   logic cg [9] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
   // ****************************************************
   // clock and device
   // ****************************************************
   always #20 mclk_i = ~mclk_i;
   fdcu_top i_dut (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
      .start_i(start_i), .op_cmp_i(op_cmp_i), .exec_i(exec_i),
      .a_lo_i(a_lo_i), .a_hi_i(a_hi_i), .b_lo_i(b_lo_i), .b_hi_i(b_hi_i),
      .err_clr_i(err_clr_i), .busy_o(busy_o), .done_o(done_o),
      .quo_lo_o(quo_lo_o), .quo_hi_o(quo_hi_o), .ovf_o(ovf_o),
      .div_err_o(div_err_o), .gt_o(gt_o)
   );
   // ****************************************************
   // tasks
   // ****************************************************
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // one request; stress freezes the clock enable and pokes a start
   // while busy, which must be ignored
   task automatic req(input logic cmp, input logic ex,
      input logic [31:0] a, input logic [31:0] b, input int lat,
      input logic stress);
      int n;
      n = 1;
      // one idle edge keeps start low between back to back calls
      @(posedge mclk_i);
      #1;
      start_i = 1'b1;
      op_cmp_i = cmp;
      exec_i = ex;
      {a_hi_i, a_lo_i} = a;
      {b_hi_i, b_lo_i} = b;
      @(posedge mclk_i);
      #1;
      start_i = 1'b0;
      // done stands one cycle only, so look right after the taking edge
      if (lat > 1) `CHK(busy_o, 1'b1)
      while (done_o !== 1'b1 && n < 60) begin
         @(posedge mclk_i);
         #1;
         n++;
         if (stress && n == 2) clk_en_i = 1'b0;
         if (stress && n == 4) begin
            clk_en_i = 1'b1;
            start_i = 1'b1;
            op_cmp_i = 1'b1;
         end
         if (stress && n == 5) start_i = 1'b0;
      end
      `CHK(n, lat)
   endtask
   // ****************************************************
   // tests
   // ****************************************************
   initial begin
      repeat (10) @(posedge mclk_i);
      #1;
      sys_rst_i = 1'b0;
      `CHK({busy_o, done_o, ovf_o, div_err_o, gt_o}, 5'h00)
      `CHK({quo_hi_o, quo_lo_o}, 32'h00000000)
      req(1'b0, 1'b1, 32'h42280000, 32'h40800000, 28, 1'b0);
      `CHK({quo_hi_o, quo_lo_o}, 32'h41280000)
      `CHK(ovf_o, 1'b0)
      // two frozen edges stretch the walk to 30 edges
      req(1'b0, 1'b1, 32'hbf800000, 32'h40000000, 30, 1'b1);
      `CHK({quo_hi_o, quo_lo_o}, 32'hbf000000)
      req(1'b0, 1'b1, 32'h40800000, 32'h40800000, 28, 1'b0);
      `CHK({quo_hi_o, quo_lo_o}, 32'h3f800000)
      req(1'b0, 1'b1, 32'h7f000000, 32'h3e800000, 28, 1'b0);
      `CHK({quo_hi_o, quo_lo_o, ovf_o}, 33'h0fefffffe | 33'h1)
      req(1'b0, 1'b1, 32'hff000000, 32'h3e800000, 28, 1'b0);
      `CHK({quo_hi_o, quo_lo_o, ovf_o}, {32'hff7fffff, 1'b1})
      `CHK(div_err_o, 1'b0)
      // zero dividend gives signed zero and drops the overflow
      req(1'b0, 1'b1, 32'h00000000, 32'hc0000000, 1, 1'b0);
      `CHK({quo_hi_o, quo_lo_o, ovf_o}, {32'h80000000, 1'b0})
      req(1'b0, 1'b1, 32'hc0000000, 32'h00000000, 1, 1'b0);
      `CHK({quo_hi_o, quo_lo_o}, 32'hff7fffff)
      `CHK({ovf_o, div_err_o}, 2'h3)
      err_clr_i = 1'b1;
      @(posedge mclk_i);
      #1;
      `CHK(div_err_o, 1'b0)
      // clear still high: the new error must win
      req(1'b0, 1'b1, 32'h40000000, 32'h80000000, 1, 1'b0);
      err_clr_i = 1'b0;
      `CHK({quo_hi_o, quo_lo_o}, 32'hff7fffff)
      `CHK({ovf_o, div_err_o}, 2'h3)
      // underflow flushes to zero with the overflow off
      req(1'b0, 1'b1, 32'h03800000, 32'h7b800000, 28, 1'b0);
      `CHK({quo_hi_o, quo_lo_o, ovf_o}, {32'h00000000, 1'b0})
      req(1'b0, 1'b1, 32'h42280000, 32'h40800000, 28, 1'b0);
      `CHK({quo_hi_o, quo_lo_o}, 32'h41280000)
      req(1'b0, 1'b0, 32'h7f000000, 32'h00000000, 1, 1'b0);
      `CHK({quo_hi_o, quo_lo_o, ovf_o}, {32'h41280000, 1'b0})
      for (int i = 0; i < 9; i++) begin
         req(1'b1, cx[i], ca[i], cb[i], 1, 1'b0);
         `CHK(gt_o, cg[i])
         `CHK({quo_hi_o, quo_lo_o}, 32'h41280000)
      end
      give_verdict();
   end
   // ****************************************************
   // watchdog, well past the few hundred cycles of the tests
   // ****************************************************
   initial begin
      repeat (5000) @(posedge mclk_i);
      error_cnt++;
      give_verdict();
   end
endmodule
